// ===== dv/fsm_fail_safe_ctrl_assertions.sv
// checker: port-level properties of the fail-safe mode controller
`timescale 1ns/1ps

module fsm_fail_safe_ctrl_assertions #(
  parameter int PHASES = 2
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              failsafe_pin,
  input wire logic              otp_programmed,
  input wire logic              otp_locked,
  input wire logic [PHASES-1:0] phase_enable,
  input wire logic              thermal_auto_recover_en,
  input wire logic              internal_src_sel,
  input wire logic              switch_pwm,
  input wire logic              failsafe_active,
  input wire logic              autonomous_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // helper: length of the current pwm run, cleared outside fail-safe
  logic       pwm_q;
  logic [7:0] run_q;
  always_ff @(posedge clk) begin
    pwm_q <= switch_pwm;
    if (!rst_n || !failsafe_active || switch_pwm != pwm_q)
      run_q <= 8'h00;
    else if (run_q != 8'hff)
      run_q <= run_q + 8'h01;
  end

  // ==========================================================
  // properties
  src_follows_mode_a: assert property (internal_src_sel == failsafe_active)
    else $error("internal source select differs from fail-safe state");
  pwm_idle_a: assert property (!failsafe_active && !$past(failsafe_active)
    && !$past(failsafe_active, 2) |-> !switch_pwm)
    else $error("pwm toggles outside fail-safe");
  pwm_half_a: assert property (failsafe_active |-> run_q < 8'h7f)
    else $error("pwm half period longer than slowest setting");
  therm_held_a: assert property (failsafe_active |-> thermal_auto_recover_en)
    else $error("thermal recovery low in fail-safe");
  phase_all_on_a: assert property (failsafe_active && !autonomous_mode
    |-> &phase_enable)
    else $error("phase enables not all set in pin fail-safe");
  pin_entry_a: assert property ($rose(failsafe_active) && !autonomous_mode
    |-> !$past(failsafe_pin) && $past(failsafe_pin, 2))
    else $error("fail-safe entered without a pin fall");
  sa_in_fs_a: assert property (autonomous_mode |-> failsafe_active)
    else $error("stand-alone without fail-safe");
  otp_guard_a: assert property ($rose(failsafe_active)
    |-> $past(otp_programmed) && $past(otp_locked))
    else $error("fail-safe entered with otp not locked");
endmodule // fsm_fail_safe_ctrl_assertions

bind fsm_fail_safe_ctrl fsm_fail_safe_ctrl_assertions #(.PHASES(PHASES)) u_chk (
  .clk(clk), .rst_n(rst_n), .failsafe_pin(failsafe_pin),
  .otp_programmed(otp_programmed), .otp_locked(otp_locked),
  .phase_enable(phase_enable),
  .thermal_auto_recover_en(thermal_auto_recover_en),
  .internal_src_sel(internal_src_sel), .switch_pwm(switch_pwm),
  .failsafe_active(failsafe_active), .autonomous_mode(autonomous_mode));

// ===== dv/fsm_mcu_model.sv
// partner: controller side driving the fail-safe pin and frame errors
`timescale 1ns/1ps

module fsm_mcu_model (
  input  wire logic clk,
  input  wire logic pin_req,
  input  wire logic bad_tgl,
  output logic      failsafe_pin,
  output logic      frame_invalid
);
  logic tgl_q;
  // a toggle request becomes one error pulse, never a held level
  always_ff @(posedge clk) begin
    failsafe_pin  <= pin_req;
    tgl_q         <= bad_tgl;
    frame_invalid <= bad_tgl ^ tgl_q;
  end
endmodule // fsm_mcu_model

// ===== dv/tb_top.sv
// testbench: register and pin sequences for the fail-safe controller
`timescale 1ns/1ps

module tb_top;
  import fsm_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, pin_req, bad_tgl, otp_ok, otp_pg;
  // half periods in cycles of the 50 MHz clock, select 0..7
  localparam int half_exp [8] = '{125, 85, 60, 50, 40, 35, 30, 25};
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [9:0] otp_w;
  logic [1:0] ph;
  logic fs_pin, bad, therm, src, pwm, act, sa, irq;
  int err_total, n_tests, cyc, n;

  fsm_fail_safe_ctrl fsm_fail_safe_ctrl_inst (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_ctrl_word(otp_w),
    .otp_programmed(otp_pg), .otp_locked(otp_ok), .failsafe_pin(fs_pin),
    .frame_invalid(bad), .phase_enable(ph), .thermal_auto_recover_en(therm),
    .internal_src_sel(src), .switch_pwm(pwm), .failsafe_active(act),
    .autonomous_mode(sa), .irq(irq));
  fsm_mcu_model fsm_mcu_model_inst (.clk(clk), .pin_req(pin_req),
    .bad_tgl(bad_tgl), .failsafe_pin(fs_pin), .frame_invalid(bad));

  // ==========================================================
  // clock, timeout and helpers
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rst(input logic [9:0] w, input logic ok);
    @(posedge clk);
    otp_w <= w; otp_ok <= ok; rst_n <= 1'b0; pin_req <= 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic pin(input logic v);
    @(posedge clk);
    pin_req <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // one full run of the pwm after the next toggle
  task automatic half();
    logic p;
    p = pwm; n = 0;
    while (pwm === p && n < 300) begin @(posedge clk); #1; n++; end
    p = pwm; n = 0;
    while (pwm === p && n < 300) begin @(posedge clk); #1; n++; end
  endtask
  // ==========================================================
  // scenarios
  initial begin
    {rst_n, reg_wr, reg_rd, bad_tgl, otp_ok} = '0;
    {reg_addr, reg_wdata, otp_w} = '0; pin_req = 1'b1; otp_pg = 1'b1;
    err_total = 0; n_tests = 0; cyc = 0;
    rst(10'h3f8, 1'b1); rd(8'h00); chk(d, 32'h0);
    pin(1'b0); chk(act, 1'b0);
    rst(10'h1b1, 1'b1); rd(8'h00); chk(d, 32'h1b1);
    chk(therm, 1'b1);
    pin(1'b0); chk(act, 1'b0);
    // code 2: control writes locked out in fail-safe
    rst(10'h1f2, 1'b1); rd(8'h00); chk(d, 32'h002);
    chk(therm, 1'b0);
    wr(8'h0c, 32'h1); pin(1'b0);
    chk({act, src, therm, ph}, 5'h1f);
    chk(irq, 1'b1); wr(8'h08, 32'h1); chk(irq, 1'b0);
    rd(8'h00); chk(d, 32'h172);
    half(); chk(n, half_exp[7]);
    wr(8'h00, 32'h0); rd(8'h00); chk(d, 32'h172);
    // error pulse needs two edges through the model and the flag
    bad_tgl <= ~bad_tgl; repeat (3) @(posedge clk);
    rd(8'h04); chk(d, 32'h7);
    rd(8'h04); chk(d, 32'h6);
    rd(8'h20); chk(d, 32'h0);
    pin(1'b1); chk({act, ph}, 3'h1);
    // code 3: writes allowed, frequency sweep, exits by write
    rst(10'h003, 1'b1); pin(1'b0); chk(act, 1'b1);
    for (int s = 0; s < 8; s++) begin
      wr(8'h00, 32'(s * 16 + 3));
      half(); half(); chk(n, half_exp[s]);
      chk(therm, 1'b1);
    end
    wr(8'h00, 32'h00b); chk({act, ph}, 3'h0);
    pin(1'b1); pin(1'b0); chk(act, 1'b0);
    wr(8'h00, 32'h003); pin(1'b1); pin(1'b0); chk(act, 1'b1);
    wr(8'h00, 32'h000); chk(act, 1'b0);
    rst(10'h006, 1'b1); chk({act, sa, src}, 3'h7);
    rst(10'h006, 1'b0); chk({act, sa}, 2'h0);
    otp_pg <= 1'b0; rst(10'h006, 1'b1); chk({act, sa}, 2'h0);
    end_sim();
  end
endmodule // tb_top

// ===== hdl/fsm_fail_safe_ctrl.sv
// module: fail-safe and stand-alone mode controller of a booster driver
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module fsm_fail_safe_ctrl
  import fsm_pkg::*;
#(
  parameter int PHASES = FSM_PHASES
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  input  wire logic [9:0]          otp_ctrl_word,
  input  wire logic                otp_programmed,
  input  wire logic                otp_locked,
  input  wire logic                failsafe_pin,
  input  wire logic                frame_invalid,
  output logic [PHASES-1:0]        phase_enable,
  output logic                     thermal_auto_recover_en,
  output logic                     internal_src_sel,
  output logic                     switch_pwm,
  output logic                     failsafe_active,
  output logic                     autonomous_mode,
  output logic                     irq
);

  // ==========================================================
  // state
  fsm_state_t        state_q, state_d;
  logic [9:0]        ctrl_q, ctrl_d;
  logic [PHASES-1:0] phase_pre_q, phase_pre_d;
  logic              via_pin_q, via_pin_d;
  logic              auto_q, auto_d;
  logic              pin_q;
  logic              entered_q, serr_q;
  logic [2:0]        irq_stat_q, irq_mask_q;
  logic [31:0]       rdata_q;

  // ==========================================================
  // decode
  wire logic [2:0] mode_code    = ctrl_q[FSM_MODE_LSB +: 3];
  wire logic       pin_sel      = ctrl_q[FSM_PINSEL_BIT];
  wire logic [2:0] otp_mode     = otp_ctrl_word[FSM_MODE_LSB +: 3];
  wire logic       otp_ok       = otp_programmed & otp_locked;
  wire logic       pin_fall     = pin_q & ~failsafe_pin;
  wire logic       pin_rise     = ~pin_q & failsafe_pin;
  wire logic       in_fs        = (state_q == FSM_ST_FAILSAFE);
  wire logic       wr_ctrl      = reg_wr & (reg_addr == FSM_OFS_CTRL);
  wire logic       wr_istat     = reg_wr & (reg_addr == FSM_OFS_IRQ_STAT);
  wire logic       wr_imask     = reg_wr & (reg_addr == FSM_OFS_IRQ_MASK);
  wire logic       rd_status    = reg_rd & (reg_addr == FSM_OFS_STATUS);
  // even codes (010, 100, 110) block control register writes in fail-safe
  wire logic       writes_open  = mode_code[0];
  wire logic       wr_blocked   = in_fs & ~writes_open;
  wire logic       wr_accept    = wr_ctrl & ~wr_blocked;
  wire logic [2:0] new_mode     = reg_wdata[FSM_MODE_LSB +: 3];
  wire logic       new_pin_sel  = reg_wdata[FSM_PINSEL_BIT];
  // codes that arm the pin: 010..101 and 111 after register update
  wire logic       pin_armed    = ((mode_code >= 3'h2) &&
                                   (mode_code <= 3'h5)) ||
                                  (mode_code == 3'h7);
  wire logic       enter_pin    = (state_q == FSM_ST_NORMAL) & pin_armed &
                                  ~pin_sel & pin_fall & otp_ok;
  wire logic       exit_pin     = in_fs & via_pin_q & ~pin_sel &
                                  pin_rise;
  wire logic       exit_wr      = in_fs & wr_accept &
                                  ((new_mode == FSM_MD_OFF_ZERO) ||
                                   (new_mode == FSM_MD_OFF_OTP) ||
                                   new_pin_sel);
  wire logic       entering     = (state_d == FSM_ST_FAILSAFE) & ~in_fs;
  wire logic       leaving      = in_fs & (state_d != FSM_ST_FAILSAFE);

  // otp image with thermal bit only honoured under code 1
  function automatic logic [9:0] otp_image(input logic [2:0] md,
                                           input logic keep_th);
    logic [9:0] w;
    w = otp_ctrl_word;
    if (md != FSM_MD_OFF_OTP) begin
      w[FSM_THERM_BIT] = keep_th;
    end
    return w;
  endfunction

  // ==========================================================
  // mode sequencing and control register
  always_comb begin
    state_d     = state_q;
    ctrl_d      = ctrl_q;
    phase_pre_d = phase_pre_q;
    via_pin_d   = via_pin_q;
    auto_d      = auto_q;
    case (state_q)
      FSM_ST_INIT: begin
        // mode code comes from otp only once, here at power-up
        if (!otp_ok) begin
          ctrl_d    = FSM_CTRL_RST;
          state_d   = FSM_ST_NORMAL;
        end else begin
          case (otp_mode)
            3'h0, 3'h2, 3'h3: begin
              ctrl_d = FSM_CTRL_RST;
              ctrl_d[FSM_MODE_LSB +: 3] = otp_mode;
              state_d = FSM_ST_NORMAL;
            end
            3'h1, 3'h4, 3'h5: begin
              ctrl_d  = otp_image(otp_mode, 1'b0);
              state_d = FSM_ST_NORMAL;
            end
            default: begin
              ctrl_d  = otp_image(otp_mode, 1'b0);
              state_d = FSM_ST_FAILSAFE;
              auto_d  = 1'b1;
            end
          endcase
        end
        phase_pre_d = ctrl_d[FSM_PHASE_LSB +: PHASES];
        via_pin_d   = 1'b0;
      end
      FSM_ST_NORMAL: begin
        if (enter_pin) begin
          // reload keeps the live mode code, set at power-up or by a control write
          ctrl_d = otp_image(mode_code, ctrl_q[FSM_THERM_BIT]);
          ctrl_d[FSM_MODE_LSB +: 3] = mode_code;
          phase_pre_d = ctrl_d[FSM_PHASE_LSB +: PHASES];
          via_pin_d   = 1'b1;
          state_d     = FSM_ST_FAILSAFE;
        end else if (wr_accept) begin
          ctrl_d = reg_wdata[FSM_CTRL_W-1:0];
        end
      end
      FSM_ST_FAILSAFE: begin
        if (wr_accept) begin
          ctrl_d = reg_wdata[FSM_CTRL_W-1:0];
        end
        if (exit_wr || exit_pin) begin
          state_d   = FSM_ST_NORMAL;
          via_pin_d = 1'b0;
          auto_d    = 1'b0;
        end
      end
      default: begin
        state_d = FSM_ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= FSM_ST_INIT;
      ctrl_q      <= FSM_CTRL_RST;
      phase_pre_q <= '0;
      via_pin_q   <= 1'b0;
      auto_q      <= 1'b0;
      pin_q       <= 1'b1;
    end else begin
      state_q     <= state_d;
      ctrl_q      <= ctrl_d;
      phase_pre_q <= phase_pre_d;
      via_pin_q   <= via_pin_d;
      auto_q      <= auto_d;
      pin_q       <= failsafe_pin;
    end
  end

  // ==========================================================
  // status flags: a set in the cycle of the clear wins
  wire logic clr_open = rd_status & ~wr_blocked;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      entered_q <= 1'b0;
      serr_q    <= 1'b0;
    end else begin
      entered_q <= entering | (entered_q & ~rd_status);
      serr_q    <= frame_invalid | (serr_q & ~clr_open);
    end
  end

  // ==========================================================
  // interrupts: sticky events, write one to clear, masked level out
  wire logic [2:0] irq_evt = {wr_ctrl & wr_blocked, leaving, entering};
  wire logic [2:0] irq_stat_d =
    irq_evt | (irq_stat_q & ~(wr_istat ? reg_wdata[2:0] : 3'h0));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_q <= FSM_IRQ_RST;
      irq_mask_q <= FSM_IRQ_RST;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_imask) begin
        irq_mask_q <= reg_wdata[2:0];
      end
      irq <= |(irq_stat_d & (wr_imask ? reg_wdata[2:0] : irq_mask_q));
    end
  end

  // ==========================================================
  // register read port: data in the cycle after the strobe
  wire logic [31:0] status_word = {28'h0, auto_q, in_fs, serr_q, entered_q};
  wire logic [31:0] rd_mux =
    (reg_addr == FSM_OFS_CTRL)     ? {22'h0, ctrl_q}          :
    (reg_addr == FSM_OFS_STATUS)   ? status_word              :
    (reg_addr == FSM_OFS_IRQ_STAT) ? {29'h0, irq_stat_q}      :
    (reg_addr == FSM_OFS_IRQ_MASK) ? {29'h0, irq_mask_q}      :
                                     32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================
  // internal 50% switching source
  // half period rounded to nearest whole cycle; 294.1 kHz gives 85
  function automatic logic [FSM_HALF_W-1:0] half_cnt(input logic [2:0] s);
    int hz;
    hz = FSM_FREQ_HZ[s];
    return FSM_HALF_W'((FSM_CLK_HZ + hz) / (2 * hz));
  endfunction

  logic [FSM_HALF_W-1:0] cnt_q;
  logic [2:0]            sel_q;
  logic                  pwm_q;
  wire logic [2:0]       freq_sel = ctrl_q[FSM_FREQ_LSB +: 3];
  wire logic             half_end = (cnt_q == half_cnt(sel_q) - 1'b1);

  always_ff @(posedge clk) begin
    if (!rst_n || !in_fs) begin
      cnt_q <= '0;
      // entry takes the reloaded select at once, not the stale one
      sel_q <= ctrl_d[FSM_FREQ_LSB +: 3];
      pwm_q <= 1'b0;
    end else if (half_end) begin
      cnt_q <= '0;
      pwm_q <= ~pwm_q;
      // new select only after the high half, so no runt pulse
      if (!pwm_q) begin
        sel_q <= sel_q;
      end else begin
        sel_q <= freq_sel;
      end
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // outputs, all registered
  wire logic [PHASES-1:0] ph_reg = ctrl_q[FSM_PHASE_LSB +: PHASES];
  wire logic              fs_d   = (state_d == FSM_ST_FAILSAFE);
  wire logic              pin_d  = via_pin_d & fs_d;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_enable            <= '0;
      thermal_auto_recover_en <= 1'b0;
      internal_src_sel        <= 1'b0;
      switch_pwm              <= 1'b0;
      failsafe_active         <= 1'b0;
      autonomous_mode         <= 1'b0;
    end else begin
      // forced on only while pin-entered; after exit the register rules,
      // so phases preloaded zero and never written stay off
      phase_enable            <= pin_d ? '1 :
                                 ctrl_d[FSM_PHASE_LSB +: PHASES];
      thermal_auto_recover_en <= fs_d | ctrl_d[FSM_THERM_BIT];
      internal_src_sel        <= fs_d;
      switch_pwm              <= in_fs & pwm_q;
      failsafe_active         <= fs_d;
      autonomous_mode         <= auto_d;
    end
  end

endmodule // fsm_fail_safe_ctrl

// ===== hdl/fsm_pkg.sv
// package: constants for the fail-safe mode controller
package fsm_pkg;

  // ==========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] FSM_OFS_CTRL     = 8'h00;
  localparam logic [7:0] FSM_OFS_STATUS   = 8'h04;
  localparam logic [7:0] FSM_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] FSM_OFS_IRQ_MASK = 8'h0c;

  // ==========================================================
  // control word layout (same layout as the otp image)
  localparam int FSM_CTRL_W        = 10;
  localparam int FSM_MODE_LSB      = 0;
  localparam int FSM_PINSEL_BIT    = 3;
  localparam int FSM_FREQ_LSB      = 4;
  localparam int FSM_THERM_BIT     = 7;
  localparam int FSM_PHASE_LSB     = 8;
  localparam int FSM_PHASES        = 2;
  localparam logic [9:0] FSM_CTRL_RST = 10'h000;

  // ==========================================================
  // status and interrupt bit positions
  localparam int FSM_ST_ENTERED  = 0;
  localparam int FSM_ST_SERR     = 1;
  localparam int FSM_ST_ACTIVE   = 2;
  localparam int FSM_ST_AUTO     = 3;
  localparam int FSM_IRQ_W       = 3;
  localparam int FSM_IRQ_ENTER   = 0;
  localparam int FSM_IRQ_EXIT    = 1;
  localparam int FSM_IRQ_BLOCKED = 2;
  localparam logic [2:0] FSM_IRQ_RST = 3'h0;

  // ==========================================================
  // mode codes
  localparam logic [2:0] FSM_MD_OFF_ZERO = 3'h0;
  localparam logic [2:0] FSM_MD_OFF_OTP  = 3'h1;

  // ==========================================================
  // timing: system clock and internal switching frequencies in hz
  localparam int FSM_CLK_HZ = 50000000;
  localparam int FSM_FREQ_HZ [8] = '{200000, 294100, 416700, 500000,
                                     625000, 714300, 833000, 1000000};
  localparam int FSM_HALF_W = 8;

  typedef enum logic [1:0] {
    FSM_ST_INIT,
    FSM_ST_NORMAL,
    FSM_ST_FAILSAFE
  } fsm_state_t;

endpackage
